// ===== hdl/edc_config_regs.sv
// event detect, capture mode and offset configuration bank
// byte register port from the configuration serial decoder;
// results, error pulses and capture progress from the datapath,
// all on the one sample clock
//
// Behaviour
// - detection fed only while enable bit set
// - bit 6 routes or masks upper detect
// - bit 5 routes or masks lower detect
// - bit 4 routes errors, never to capture
// - two-bit field selects capture behaviour
// - written depth clamped between 1 and 16384
// - depth is 15 bits, resets 0x4000
// - full-readout mode reads back event location once depth reached
// - other modes read back programmed depth
// - hysteresis is 11-bit unsigned step count
// - upper limit 12-bit two's complement
// - lower limit 12-bit two's complement
// - offset 12-bit two's complement, reset zero
// - 16-bit settings span two byte addresses
// - alert pin output is active low
`timescale 1ns/1ns
module edc_config_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic resultValid,
  input wire logic [19:0] resultData,
  input wire logic conversionError,
  input wire logic depthReached,
  input wire logic [14:0] eventLocation,
  output logic correctedValid,
  output logic [19:0] correctedData,
  output edc_pkg::edc_status_t routedStatus,
  output logic captureEvent,
  output logic statusAlert_n,
  output logic [1:0] captureMode,
  output logic [14:0] captureDepth
);

  // --------------------------------------------------------------
  // functions
  // --------------------------------------------------------------
  function automatic logic [14:0] clampDepth(input logic [15:0] v);
    if (v < edc_pkg::DEPTH_MIN)
      clampDepth = edc_pkg::DEPTH_MIN[14:0];
    else if (v > edc_pkg::DEPTH_MAX)
      clampDepth = edc_pkg::DEPTH_MAX[14:0];
    else
      clampDepth = v[14:0];
  endfunction

  function automatic logic [19:0] satAdd(input logic [19:0] a,
                                         input logic [11:0] b);
    logic [20:0] sum;
    sum = {a[19], a} + {{9{b[11]}}, b};
    if (sum[20] != sum[19])
      satAdd = sum[20] ? 20'h80000 : 20'h7ffff;
    else
      satAdd = sum[19:0];
  endfunction

  function automatic logic isAddr(input logic [7:0] a,
                                  input logic [7:0] b);
    isAddr = (a == b);
  endfunction

  function automatic edc_pkg::edc_route_t routeFromByte(
    input logic [7:0] b
  );
    edc_pkg::edc_route_t r;
    r.detectEnable = b[edc_pkg::BIT_DETECT_EN];
    r.upperDetectForward = b[edc_pkg::BIT_UPPER_FWD];
    r.lowerDetectForward = b[edc_pkg::BIT_LOWER_FWD];
    r.conversionErrorForward = b[edc_pkg::BIT_ERROR_FWD];
    r.captureMode = b[edc_pkg::BIT_MODE_LSB +: 2];
    routeFromByte = r;
  endfunction

  function automatic logic [7:0] byteFromRoute(
    input edc_pkg::edc_route_t r
  );
    logic [7:0] b;
    b = 8'h00;
    b[edc_pkg::BIT_DETECT_EN] = r.detectEnable;
    b[edc_pkg::BIT_UPPER_FWD] = r.upperDetectForward;
    b[edc_pkg::BIT_LOWER_FWD] = r.lowerDetectForward;
    b[edc_pkg::BIT_ERROR_FWD] = r.conversionErrorForward;
    b[edc_pkg::BIT_MODE_LSB +: 2] = r.captureMode;
    byteFromRoute = b;
  endfunction

  localparam edc_pkg::edc_route_t ROUTE_RESET =
    routeFromByte(edc_pkg::RST_ROUTE_MODE);

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  edc_pkg::edc_route_t route;
  logic [14:0] depth;
  logic [10:0] hyst;
  logic [11:0] upperLimit;
  logic [11:0] lowerLimit;
  logic [11:0] offsetCoef;
  logic [7:0] lowStage;
  logic [14:0] location;
  edc_pkg::edc_readback_t readback;
  edc_pkg::edc_readback_t next_readback;

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  wire logic wrRoute = regWrEn &&
    isAddr(regAddr, edc_pkg::ADDR_ROUTE_MODE);
  wire logic wrLowByte = regWrEn && (
    isAddr(regAddr, edc_pkg::ADDR_DEPTH_LO) ||
    isAddr(regAddr, edc_pkg::ADDR_HYST_LO) ||
    isAddr(regAddr, edc_pkg::ADDR_UPPER_LO) ||
    isAddr(regAddr, edc_pkg::ADDR_LOWER_LO) ||
    isAddr(regAddr, edc_pkg::ADDR_OFFSET_LO));
  wire logic wrDepth = regWrEn &&
    isAddr(regAddr, edc_pkg::ADDR_DEPTH_HI);
  wire logic wrHyst = regWrEn &&
    isAddr(regAddr, edc_pkg::ADDR_HYST_HI);
  wire logic wrUpper = regWrEn &&
    isAddr(regAddr, edc_pkg::ADDR_UPPER_HI);
  wire logic wrLower = regWrEn &&
    isAddr(regAddr, edc_pkg::ADDR_LOWER_HI);
  wire logic wrOffset = regWrEn &&
    isAddr(regAddr, edc_pkg::ADDR_OFFSET_HI);
  wire logic [15:0] pairWord = {regWrData, lowStage};

  // --------------------------------------------------------------
  // write side
  // --------------------------------------------------------------
  wire logic [7:0] routeWord = regWrData & edc_pkg::ROUTE_WMASK;
  wire logic [15:0] depthWord = pairWord & edc_pkg::DEPTH_WMASK;
  wire logic [15:0] hystWord = pairWord & edc_pkg::HYST_WMASK;
  wire logic [15:0] limitWord = pairWord & edc_pkg::LIMIT_WMASK;
  wire edc_pkg::edc_route_t writtenRoute = routeFromByte(routeWord);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lowStage <= 8'h00;
    else if (wrLowByte)
      lowStage <= regWrData;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      route <= ROUTE_RESET;
    else if (wrRoute)
      route <= writtenRoute;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      depth <= edc_pkg::RST_DEPTH;
    else if (wrDepth)
      depth <= clampDepth(depthWord);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hyst <= edc_pkg::RST_HYST;
    else if (wrHyst)
      hyst <= hystWord[10:0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upperLimit <= edc_pkg::RST_LIMIT;
      lowerLimit <= edc_pkg::RST_LIMIT;
      offsetCoef <= edc_pkg::RST_OFFSET;
    end
    else
    begin
      if (wrUpper)
        upperLimit <= limitWord[11:0];
      if (wrLower)
        lowerLimit <= limitWord[11:0];
      if (wrOffset)
        offsetCoef <= limitWord[11:0];
    end
  end

  // --------------------------------------------------------------
  // depth readback state: programmed depth or event location
  // --------------------------------------------------------------
  wire logic allMode = (route.captureMode == edc_pkg::MODE_EVENT_ALL);

  always_comb
  begin
    next_readback = readback;
    case (readback)
      edc_pkg::SHOW_DEPTH:
        if (allMode && depthReached)
          next_readback = edc_pkg::SHOW_LOCATION;
      edc_pkg::SHOW_LOCATION:
        if (!allMode || (wrDepth && !depthReached))
          next_readback = edc_pkg::SHOW_DEPTH;
      default:
        next_readback = edc_pkg::SHOW_DEPTH;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      readback <= edc_pkg::SHOW_DEPTH;
    else
      readback <= next_readback;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      location <= 15'h0000;
    else if (allMode && depthReached)
      location <= eventLocation;
  end

  wire logic showLocation = allMode &&
    (readback == edc_pkg::SHOW_LOCATION);
  wire logic [15:0] depthRead = showLocation ?
    {1'b0, location} : {1'b0, depth};

  // --------------------------------------------------------------
  // read side
  // --------------------------------------------------------------
  wire logic [7:0] routeRead = byteFromRoute(route);
  wire logic [15:0] hystRead = {5'h00, hyst};
  wire logic [15:0] upperRead = {4'h0, upperLimit};
  wire logic [15:0] lowerRead = {4'h0, lowerLimit};
  wire logic [15:0] offsetRead = {4'h0, offsetCoef};
  wire logic [7:0] readMux =
    isAddr(regAddr, edc_pkg::ADDR_ROUTE_MODE) ? routeRead :
    isAddr(regAddr, edc_pkg::ADDR_DEPTH_LO) ? depthRead[7:0] :
    isAddr(regAddr, edc_pkg::ADDR_DEPTH_HI) ? depthRead[15:8] :
    isAddr(regAddr, edc_pkg::ADDR_HYST_LO) ? hystRead[7:0] :
    isAddr(regAddr, edc_pkg::ADDR_HYST_HI) ? hystRead[15:8] :
    isAddr(regAddr, edc_pkg::ADDR_UPPER_LO) ? upperRead[7:0] :
    isAddr(regAddr, edc_pkg::ADDR_UPPER_HI) ? upperRead[15:8] :
    isAddr(regAddr, edc_pkg::ADDR_LOWER_LO) ? lowerRead[7:0] :
    isAddr(regAddr, edc_pkg::ADDR_LOWER_HI) ? lowerRead[15:8] :
    isAddr(regAddr, edc_pkg::ADDR_OFFSET_LO) ? offsetRead[7:0] :
    isAddr(regAddr, edc_pkg::ADDR_OFFSET_HI) ? offsetRead[15:8] :
    8'h00;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      regRdData <= 8'h00;
    else if (regRdEn)
      regRdData <= readMux;
  end

  // --------------------------------------------------------------
  // offset correction of results
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      correctedValid <= 1'b0;
      correctedData <= 20'h00000;
    end
    else
    begin
      correctedValid <= resultValid;
      if (resultValid)
        correctedData <= satAdd(resultData, offsetCoef);
    end
  end

  // --------------------------------------------------------------
  // threshold detection
  // --------------------------------------------------------------
  logic upperDetect;
  logic lowerDetect;
  wire logic detectFeed = correctedValid && route.detectEnable;

  edc_hyst_detect #(.IS_UPPER(1'b1)) upperDetector (
    .clock(clock),
    .rst_n(rst_n),
    .enable(route.detectEnable),
    .sampleValid(detectFeed),
    .sample(correctedData[19:8]),
    .limit(upperLimit),
    .hyst(hyst),
    .detect(upperDetect)
  );

  edc_hyst_detect #(.IS_UPPER(1'b0)) lowerDetector (
    .clock(clock),
    .rst_n(rst_n),
    .enable(route.detectEnable),
    .sampleValid(detectFeed),
    .sample(correctedData[19:8]),
    .limit(lowerLimit),
    .hyst(hyst),
    .detect(lowerDetect)
  );

  // --------------------------------------------------------------
  // status routing
  // --------------------------------------------------------------
  wire logic upperRouted = upperDetect && route.upperDetectForward;
  wire logic lowerRouted = lowerDetect && route.lowerDetectForward;
  wire logic errorRouted = conversionError &&
    route.conversionErrorForward;
  wire logic captureArmed = (route.captureMode == edc_pkg::MODE_EVENT_LATEST)
    || allMode;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      routedStatus <= 3'h0;
      captureEvent <= 1'b0;
      statusAlert_n <= 1'b1;
    end
    else
    begin
      routedStatus <= {upperRouted, lowerRouted, errorRouted};
      captureEvent <= captureArmed &&
        (upperRouted || lowerRouted);
      statusAlert_n <= !(upperRouted || lowerRouted ||
        errorRouted);
    end
  end

  assign captureMode = route.captureMode;
  assign captureDepth = depth;

endmodule // edc_config_regs

// ===== hdl/edc_hyst_detect.sv
// threshold detector with hysteresis for one limit
// assumes samples and limits in the same 12-bit signed scale
`timescale 1ns/1ns
module edc_hyst_detect #(
  parameter bit IS_UPPER = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic sampleValid,
  input wire logic [11:0] sample,
  input wire logic [11:0] limit,
  input wire logic [10:0] hyst,
  output logic detect
);

  // --------------------------------------------------------------
  // widened signed compare
  // --------------------------------------------------------------
  wire logic signed [13:0] sampleWide = {{2{sample[11]}}, sample};
  wire logic signed [13:0] limitWide = {{2{limit[11]}}, limit};
  wire logic signed [13:0] hystWide = {3'h0, hyst};
  wire logic signed [13:0] releaseLevel = IS_UPPER ?
    limitWide - hystWide : limitWide + hystWide;
  wire logic crossIn = IS_UPPER ? (sampleWide > limitWide) :
    (sampleWide < limitWide);
  wire logic crossOut = IS_UPPER ? (sampleWide < releaseLevel) :
    (sampleWide > releaseLevel);
  wire logic next_detect = !enable ? 1'b0 :
    !sampleValid ? detect :
    crossIn ? 1'b1 :
    crossOut ? 1'b0 : detect;

  // --------------------------------------------------------------
  // detect state
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      detect <= 1'b0;
    else
      detect <= next_detect;
  end

endmodule // edc_hyst_detect

// ===== hdl/edc_pkg.sv
// package of the event detect and capture configuration bank
// offsets, field positions, reset values and shared types
// assumes byte-wide register access from the configuration port
package edc_pkg;

  // --------------------------------------------------------------
  // register byte addresses, low byte of each pair first
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_ROUTE_MODE = 8'h1c;
  localparam logic [7:0] ADDR_DEPTH_LO = 8'h1d;
  localparam logic [7:0] ADDR_DEPTH_HI = 8'h1e;
  localparam logic [7:0] ADDR_HYST_LO = 8'h1f;
  localparam logic [7:0] ADDR_HYST_HI = 8'h20;
  localparam logic [7:0] ADDR_UPPER_LO = 8'h21;
  localparam logic [7:0] ADDR_UPPER_HI = 8'h22;
  localparam logic [7:0] ADDR_LOWER_LO = 8'h23;
  localparam logic [7:0] ADDR_LOWER_HI = 8'h24;
  localparam logic [7:0] ADDR_OFFSET_LO = 8'h25;
  localparam logic [7:0] ADDR_OFFSET_HI = 8'h26;

  // --------------------------------------------------------------
  // field positions of the route and mode byte
  // --------------------------------------------------------------
  localparam int BIT_DETECT_EN = 7;
  localparam int BIT_UPPER_FWD = 6;
  localparam int BIT_LOWER_FWD = 5;
  localparam int BIT_ERROR_FWD = 4;
  localparam int BIT_MODE_LSB = 0;

  // --------------------------------------------------------------
  // widths and writable masks
  // --------------------------------------------------------------
  localparam int DEPTH_W = 15;
  localparam int HYST_W = 11;
  localparam int LIMIT_W = 12;
  localparam int RESULT_W = 20;
  localparam logic [7:0] ROUTE_WMASK = 8'hf3;
  localparam logic [15:0] DEPTH_WMASK = 16'h7fff;
  localparam logic [15:0] HYST_WMASK = 16'h07ff;
  localparam logic [15:0] LIMIT_WMASK = 16'h0fff;

  // --------------------------------------------------------------
  // reset values and depth limits
  // --------------------------------------------------------------
  localparam logic [7:0] RST_ROUTE_MODE = 8'h00;
  localparam logic [14:0] RST_DEPTH = 15'h4000;
  localparam logic [10:0] RST_HYST = 11'h000;
  localparam logic [11:0] RST_LIMIT = 12'h000;
  localparam logic [11:0] RST_OFFSET = 12'h000;
  localparam logic [15:0] DEPTH_MIN = 16'h0001;
  localparam logic [15:0] DEPTH_MAX = 16'h4000;

  // --------------------------------------------------------------
  // capture modes
  // --------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_IMMEDIATE = 2'h1;
  localparam logic [1:0] MODE_EVENT_LATEST = 2'h2;
  localparam logic [1:0] MODE_EVENT_ALL = 2'h3;

  // --------------------------------------------------------------
  // shared types
  // --------------------------------------------------------------
  typedef struct packed {
    logic detectEnable;
    logic upperDetectForward;
    logic lowerDetectForward;
    logic conversionErrorForward;
    logic [1:0] captureMode;
  } edc_route_t;

  typedef struct packed {
    logic upper;
    logic lower;
    logic convError;
  } edc_status_t;

  typedef enum logic [1:0] {
    SHOW_DEPTH = 2'b01,
    SHOW_LOCATION = 2'b10
  } edc_readback_t;

endpackage

// ===== sim/edc_config_regs_sva.sv
// assertions of the event detect configuration bank
// assumes binding to edc_config_regs on its one clock
`timescale 1ns/1ns
module edc_config_regs_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic conversionError,
  input wire logic depthReached,
  input wire logic [14:0] eventLocation,
  input wire edc_pkg::edc_status_t routedStatus,
  input wire logic statusAlert_n,
  input wire logic [1:0] captureMode,
  input wire logic [14:0] captureDepth
);
  logic [7:0] route;
  logic [7:0] lowStage;
  logic [15:0] pairVal;
  logic [14:0] expDepth;
  assign pairVal = {regWrData, lowStage};
  assign expDepth = (pairVal == 16'h0000) ? 15'h0001 :
    (pairVal > 16'h4000) ? 15'h4000 : pairVal[14:0];

  // shadow of route byte and staged depth low byte
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      route <= 8'h00;
      lowStage <= 8'h00;
    end
    else
    begin
      if (regWrEn && regAddr == 8'h1c)
        route <= regWrData & 8'hf3;
      if (regWrEn && regAddr == 8'h1d)
        lowStage <= regWrData;
    end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence locSeen;
    captureMode == 2'h3 && depthReached;
  endsequence

  sequence depthLoRead;
    regRdEn && regAddr == 8'h1d;
  endsequence

  chk_mode_field: assert property (
    regWrEn && regAddr == 8'h1c |=> captureMode == $past(regWrData[1:0]))
    else $error("capture mode wrong");
  chk_error_route: assert property (
    routedStatus.convError == $past(conversionError && route[4]))
    else $error("error routing wrong");
  chk_detect_off: assert property (
    !route[7] [*4] |-> !routedStatus.upper && !routedStatus.lower)
    else $error("detect while disabled");
  chk_upper_mask: assert property (
    !route[6] [*3] |-> !routedStatus.upper)
    else $error("upper not masked");
  chk_lower_mask: assert property (
    !route[5] [*3] |-> !routedStatus.lower)
    else $error("lower not masked");
  chk_alert_level: assert property (
    statusAlert_n == !(routedStatus.upper || routedStatus.lower ||
    routedStatus.convError))
    else $error("alert level wrong");
  chk_depth_clamp: assert property (
    regWrEn && regAddr == 8'h1e |=> captureDepth == $past(expDepth))
    else $error("depth not clamped");
  chk_depth_read: assert property (
    regRdEn && regAddr == 8'h1d && captureMode != 2'h3
    |=> regRdData == $past(captureDepth[7:0]))
    else $error("depth readback wrong");
  chk_location_read: assert property (
    locSeen ##[1:4] depthLoRead |=> regRdData == $past(eventLocation[7:0]))
    else $error("location readback wrong");
  chk_unmapped_zero: assert property (
    regRdEn && (regAddr < 8'h1c || regAddr > 8'h26) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
endmodule // edc_config_regs_sva

bind edc_config_regs edc_config_regs_sva edc_config_regs_sva_i (
  .clock(clock),
  .rst_n(rst_n),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWrEn(regWrEn),
  .regRdEn(regRdEn),
  .regRdData(regRdData),
  .conversionError(conversionError),
  .depthReached(depthReached),
  .eventLocation(eventLocation),
  .routedStatus(routedStatus),
  .statusAlert_n(statusAlert_n),
  .captureMode(captureMode),
  .captureDepth(captureDepth)
);

// ===== sim/edc_host_model.sv
// host model driving the byte register port
// assumes one-cycle strobes taken at the rising clock edge
`timescale 1ns/1ns
module edc_host_model (
  input wire logic clock,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn
);
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
    regWrData <= ~d;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask

  // low byte staged first, high byte commits the pair
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
  endtask
endmodule // edc_host_model

// ===== sim/tb.sv
// bench of the event detect configuration bank
// assumes edc_host_model drives the register port
`timescale 1ns/1ns
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic resultValid = 1'b0;
  logic [19:0] resultData = 20'h00000;
  logic conversionError = 1'b0;
  logic depthReached = 1'b0;
  logic [14:0] eventLocation = 15'h0000;
  logic [7:0] regAddr, regWrData, regRdData, rdByte;
  logic regWrEn, regRdEn, correctedValid, captureEvent, statusAlert_n;
  logic [19:0] correctedData, corr;
  logic [1:0] captureMode;
  logic [14:0] captureDepth;
  logic [15:0] word;
  logic [4:0] outs;
  edc_pkg::edc_status_t routedStatus;
  int fails = 0;
  int compares = 0;
  logic [15:0] dIn [4] = '{16'h0000, 16'h4001, 16'h0003, 16'h4000};
  logic [15:0] dOut [4] = '{16'h0001, 16'h4000, 16'h0003, 16'h4000};
  logic [7:0] regA [4] = '{8'h1f, 8'h21, 8'h23, 8'h25};
  logic [15:0] regM [4] = '{16'h07ff, 16'h0fff, 16'h0fff, 16'h0fff};
  logic [11:0] smp [6] = '{12'h101, 12'h0f8, 12'h0ef, 12'heff, 12'hf08,
    12'hf11};
  logic [1:0] det [6] = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b01, 2'b00};

  assign outs = {routedStatus, captureEvent, statusAlert_n};
  always #5 clock = ~clock;

  edc_config_regs edc_config_regs_i (
    .clock(clock),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .resultValid(resultValid),
    .resultData(resultData),
    .conversionError(conversionError),
    .depthReached(depthReached),
    .eventLocation(eventLocation),
    .correctedValid(correctedValid),
    .correctedData(correctedData),
    .routedStatus(routedStatus),
    .captureEvent(captureEvent),
    .statusAlert_n(statusAlert_n),
    .captureMode(captureMode),
    .captureDepth(captureDepth)
  );
  edc_host_model edc_host_model_i (
    .clock(clock),
    .regRdData(regRdData),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn)
  );

  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    compares++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic pulse_result(input logic [19:0] d);
    @(posedge clock);
    resultValid <= 1'b1;
    resultData <= d;
    @(posedge clock);
    resultValid <= 1'b0;
    #1;
    corr = correctedData;
    check(20'(correctedValid), 20'h00001);
    repeat (3) @(posedge clock);
    #1;
    check(20'(correctedValid), 20'h00000);
  endtask

  task automatic err_pulse(input logic want);
    @(posedge clock);
    conversionError <= 1'b1;
    @(posedge clock);
    conversionError <= 1'b0;
    #1;
    check(20'(outs), want ? 20'h00004 : 20'h00001);
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (logic [7:0] a = 8'h1b; a <= 8'h27; a++)
    begin
      edc_host_model_i.rd(a, rdByte);
      check(20'(rdByte), (a == 8'h1e) ? 20'h00040 : 20'h00000);
    end
    edc_host_model_i.wr(8'h1c, 8'hff);
    edc_host_model_i.rd(8'h1c, rdByte);
    check(20'(rdByte), 20'h000f3);
    for (int m = 3; m >= 0; m--)
    begin
      edc_host_model_i.wr(8'h1c, 8'(m));
      check(20'(captureMode), 20'(m));
    end
    for (int i = 0; i < 4; i++)
    begin
      edc_host_model_i.wr16(8'h1d, dIn[i]);
      edc_host_model_i.rd16(8'h1d, word);
      check(20'(word), 20'(dOut[i]));
      check(20'(captureDepth), 20'(dOut[i]));
    end
    for (int i = 0; i < 4; i++)
    begin
      edc_host_model_i.wr16(regA[i], 16'hffff);
      edc_host_model_i.rd16(regA[i], word);
      check(20'(word), 20'(regM[i]));
    end
    edc_host_model_i.wr16(8'h25, 16'h07ff);
    pulse_result(20'h00010);
    check(corr, 20'h0080f);
    pulse_result(20'h7ffff);
    check(corr, 20'h7ffff);
    edc_host_model_i.wr16(8'h25, 16'h0800);
    pulse_result(20'h00000);
    check(corr, 20'hff800);
    edc_host_model_i.wr16(8'h25, 16'h0000);
    edc_host_model_i.wr16(8'h21, 16'h0100);
    edc_host_model_i.wr16(8'h1f, 16'h0010);
    edc_host_model_i.wr16(8'h23, 16'h0f00);
    edc_host_model_i.wr(8'h1c, 8'hf2);
    for (int i = 0; i < 6; i++)
    begin
      pulse_result({smp[i], 8'h00});
      check(20'(outs), 20'({det[i], 1'b0, |det[i], ~|det[i]}));
    end
    edc_host_model_i.wr(8'h1c, 8'he1);
    pulse_result(20'h10100);
    check(20'(outs), 20'h00010);
    edc_host_model_i.wr(8'h1c, 8'he3);
    pulse_result(20'h10100);
    check(20'(outs), 20'h00012);
    edc_host_model_i.wr(8'h1c, 8'h92);
    pulse_result(20'h10100);
    check(20'(outs), 20'h00001);
    pulse_result(20'heff00);
    check(20'(outs), 20'h00001);
    edc_host_model_i.wr(8'h1c, 8'h72);
    pulse_result(20'h10100);
    check(20'(outs), 20'h00001);
    err_pulse(1'b1);
    edc_host_model_i.wr(8'h1c, 8'h62);
    err_pulse(1'b0);
    edc_host_model_i.wr(8'h1c, 8'h03);
    edc_host_model_i.wr16(8'h1d, 16'h0008);
    @(posedge clock);
    depthReached <= 1'b1;
    eventLocation <= 15'h1234;
    @(posedge clock);
    depthReached <= 1'b0;
    edc_host_model_i.rd16(8'h1d, word);
    check(20'(word), 20'h01234);
    edc_host_model_i.wr(8'h1c, 8'h02);
    edc_host_model_i.rd16(8'h1d, word);
    check(20'(word), 20'h00008);
    close_out();
  end

  initial
  begin
    #100000;
    fails++;
    close_out();
  end
endmodule // tb
